/* File: core/isc_pkg.sv */
package isc_pkg;

  // Link widths
  localparam int IN_W        = 10;
  localparam int DATA_W      = 8;
  localparam int WORD_W      = 9;
  localparam int CTRL_BIT    = 8;
  localparam int HDR_W       = 40;

  // Cell layout
  localparam int FIFO_DEPTH  = 512;
  localparam int PAYLOAD_LEN = 48;
  localparam int HDR_LEN     = 5;
  localparam int CELL_LEN    = 53;

  // Rates, as periods
  localparam int CLK_NS      = 100;
  localparam int IN_WORD_NS  = 200;
  localparam int OUT_WORD_NS = 80;
  localparam int IN_WORD_CYC = (IN_WORD_NS + CLK_NS - 1) / CLK_NS;

  // Header values with all switches at their factory positions
  localparam logic [HDR_W-1:0] CTRL_HDR_DEF = 40'h0008004096;
  localparam logic [HDR_W-1:0] DATA_HDR_DEF = 40'h00080080d8;

  typedef enum logic [1:0] {ISC_IDLE, ISC_HDR, ISC_PAY} isc_state_t;

  // Header goes out most significant byte first, check byte last
  function automatic logic [DATA_W-1:0] hdr_byte(input logic [HDR_W-1:0] hdr,
                                                  input logic [5:0]       idx);
    logic [2:0] pos;
    pos = 3'(HDR_LEN - 1) - idx[2:0];
    return hdr[{pos, 3'h0} +: DATA_W];
  endfunction

endpackage

/* File: core/isc_packetizer.sv */
module isc_fifo #(
  parameter int W     = isc_pkg::WORD_W,
  parameter int DEPTH = isc_pkg::FIFO_DEPTH,
  parameter int LEVEL = isc_pkg::PAYLOAD_LEN
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data,
  // Packet flag
  output logic              level_flag
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign in_ready   = count != (AW+1)'(DEPTH);
  assign out_valid  = count != '0;
  assign out_data   = mem[rp];
  assign level_flag = count >= (AW+1)'(LEVEL);
  assign push       = in_valid && in_ready;
  assign pop        = out_valid && out_ready;

  // Storage is not reset; the pointers and count define content
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (push)
      begin
        wp <= wp + 1'b1;
      end
      if (pop)
      begin
        rp <= rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= '0;
    end
    else if (push && !pop)
    begin
      count <= count + 1'b1;
    end
    else if (pop && !push)
    begin
      count <= count - 1'b1;
    end
  end

  property p_fifo_bound;
    @(posedge clk) disable iff (!rst_n)
    (count == (AW+1)'(DEPTH)) |=> (count == $past(count)) || $past(pop);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound)
    else $error("fifo grew past its depth");

  property p_flag_level;
    @(posedge clk) disable iff (!rst_n)
    $rose(level_flag) |-> count == (AW+1)'(LEVEL) && $past(push);
  endproperty
  a_flag_level: assert property (p_flag_level)
    else $error("packet flag rose at wrong fill level");

endmodule

// Function
// - Input words are ten bits: eight data bits and two parity bits.
// - A control marker bit joins each input byte into a nine-bit word.
// - Input link runs at 5 MHz word rate, 40 Mb/s.
// - Words buffer in a 512 by 9 FIFO with full and empty flags.
// - Packet flag asserts while the buffer holds one full payload.
// - Each cell is 53 bytes: five header bytes then 48 payload.
// - Data and control cells each carry their own channel identifier.
// - Data cells are normal traffic carrying image or display_board header bytes.
// - A control cell announces an upcoming image stream to the display_board.
// - Output link sends eight-bit words at 12.5 MHz, 100 Mb/s; the code's handshake sends at most one word per three clk cycles, 300 ns.
// - Header switch reads 0 when on, 1 when off; switch 8 is MSB.
module isc_packetizer #(
  parameter int DEPTH = isc_pkg::FIFO_DEPTH,
  parameter int LEVEL = isc_pkg::PAYLOAD_LEN
) (
  // System clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Input link, one toggle of in_toggle per word
  input  wire logic [isc_pkg::IN_W-1:0]     in_word,
  input  wire logic                         in_ctrl,
  input  wire logic                         in_toggle,
  output logic                              in_full,
  // Header switches, low when on
  input  wire logic [isc_pkg::HDR_W-1:0]    hdr_ctrl_sw_n,
  input  wire logic [isc_pkg::HDR_W-1:0]    hdr_data_sw_n,
  // Output link
  input  wire logic                         tx_clk,
  output logic [isc_pkg::DATA_W-1:0]        tx_data,
  output logic                              tx_strobe
);
  localparam int HW = isc_pkg::HDR_W;

  logic [isc_pkg::WORD_W+1:0] in_s1;
  logic [isc_pkg::WORD_W+1:0] in_s2;
  logic                       tg_s1;
  logic                       tg_s2;
  logic                       tg_s3;
  logic [2*HW-1:0]            sw_s1;
  logic [2*HW-1:0]            sw_s2;
  logic                       wr_evt;
  logic [isc_pkg::WORD_W-1:0] wr_word;
  logic                       f_ready;
  logic                       f_valid;
  logic [isc_pkg::WORD_W-1:0] f_data;
  logic                       pkt_flag;
  logic [HW-1:0]              hdr_sel;
  isc_pkg::isc_state_t        state;
  logic [5:0]                 cnt;
  logic                       use_ctrl;
  logic                       req;
  logic [isc_pkg::DATA_W-1:0] byte_q;
  logic                       ack_s1;
  logic                       ack_s2;
  logic                       free;
  logic                       pop;
  logic                       send;
  logic [5:0]                 sent_cnt;
  logic                       trst_s1;
  logic                       trst_n;
  logic                       req_t1;
  logic                       req_t2;
  logic                       req_t3;
  logic                       ack_t;

  // Input pins pass two flops; the toggle gets a third for edge detect, so data and toggle are taken from the same stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_s1 <= '0;
      in_s2 <= '0;
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end
    else
    begin
      in_s1 <= {in_ctrl, in_word};
      in_s2 <= in_s1;
      tg_s1 <= in_toggle;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_s1 <= '1;
      sw_s2 <= '1;
    end
    else
    begin
      sw_s1 <= {hdr_ctrl_sw_n, hdr_data_sw_n};
      sw_s2 <= sw_s1;
    end
  end

  // Parity bits are dropped unchecked; a bad word still passes
  assign wr_evt  = tg_s2 ^ tg_s3;
  assign wr_word = {in_s2[isc_pkg::IN_W], in_s2[isc_pkg::DATA_W-1:0]};
  assign in_full = !f_ready;

  isc_fifo #(
    .W     (isc_pkg::WORD_W),
    .DEPTH (DEPTH),
    .LEVEL (LEVEL)
  ) u_fifo (
    .clk        (clk),
    .rst_n      (rst_n),
    .in_valid   (wr_evt),
    .in_ready   (f_ready),
    .in_data    (wr_word),
    .out_valid  (f_valid),
    .out_ready  (pop),
    .out_data   (f_data),
    .level_flag (pkt_flag)
  );

  // Switch on reads 0, so invert to get the header bits
  assign hdr_sel = use_ctrl ? ~sw_s2[2*HW-1:HW] : ~sw_s2[HW-1:0];

  assign free = req == ack_s2;
  assign pop  = state == isc_pkg::ISC_PAY && free && f_valid;
  assign send = (state == isc_pkg::ISC_HDR && free) || pop;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= isc_pkg::ISC_IDLE;
      cnt      <= '0;
      use_ctrl <= 1'b0;
    end
    else
    begin
      unique case (state)
        isc_pkg::ISC_IDLE:
        begin
          if (pkt_flag && free)
          begin
            state    <= isc_pkg::ISC_HDR;
            cnt      <= '0;
            use_ctrl <= f_data[isc_pkg::CTRL_BIT];
          end
        end
        isc_pkg::ISC_HDR:
        begin
          if (free)
          begin
            if (cnt == 6'(isc_pkg::HDR_LEN - 1))
            begin
              state <= isc_pkg::ISC_PAY;
              cnt   <= '0;
            end
            else
            begin
              cnt <= cnt + 6'h01;
            end
          end
        end
        isc_pkg::ISC_PAY:
        begin
          if (pop)
          begin
            if (cnt == 6'(isc_pkg::PAYLOAD_LEN - 1))
            begin
              state <= isc_pkg::ISC_IDLE;
              cnt   <= '0;
            end
            else
            begin
              cnt <= cnt + 6'h01;
            end
          end
        end
      endcase
    end
  end

  // One byte in flight; the source waits for the far side's ack
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_q <= '0;
      req    <= 1'b0;
    end
    else
    begin
      if (state == isc_pkg::ISC_HDR && free)
      begin
        byte_q <= isc_pkg::hdr_byte(hdr_sel, cnt);
      end
      else if (pop)
      begin
        byte_q <= f_data[isc_pkg::DATA_W-1:0];
      end
      req <= req ^ send;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end
    else
    begin
      ack_s1 <= ack_t;
      ack_s2 <= ack_s1;
    end
  end

  // Link domain: reset released through two flops
  always_ff @(posedge tx_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trst_s1 <= 1'b0;
      trst_n  <= 1'b0;
    end
    else
    begin
      trst_s1 <= 1'b1;
      trst_n  <= trst_s1;
    end
  end

  always_ff @(posedge tx_clk or negedge trst_n)
  begin
    if (!trst_n)
    begin
      req_t1    <= 1'b0;
      req_t2    <= 1'b0;
      req_t3    <= 1'b0;
      ack_t     <= 1'b0;
      tx_data   <= '0;
      tx_strobe <= 1'b0;
    end
    else
    begin
      req_t1    <= req;
      req_t2    <= req_t1;
      req_t3    <= req_t2;
      ack_t     <= req_t3;
      tx_strobe <= req_t2 ^ req_t3;
      if (req_t2 ^ req_t3)
      begin
        tx_data <= byte_q;
      end
    end
  end

  // Byte count within a cell, read only by checks
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sent_cnt <= '0;
    end
    else if (state == isc_pkg::ISC_IDLE)
    begin
      sent_cnt <= '0;
    end
    else if (send)
    begin
      sent_cnt <= sent_cnt + 6'h01;
    end
  end

  sequence s_cell_start;
    state == isc_pkg::ISC_IDLE && pkt_flag && free;
  endsequence

  sequence s_hdr_entry;
    state == isc_pkg::ISC_HDR && cnt == 6'h00;
  endsequence

  property p_pkt_start;
    @(posedge clk) disable iff (!rst_n)
    s_cell_start |=> s_hdr_entry;
  endproperty
  a_pkt_start: assert property (p_pkt_start)
    else $error("cell did not start on packet flag");

  property p_no_flag_idle;
    @(posedge clk) disable iff (!rst_n)
    (state == isc_pkg::ISC_IDLE && !pkt_flag) |=> state == isc_pkg::ISC_IDLE;
  endproperty
  a_no_flag_idle: assert property (p_no_flag_idle)
    else $error("cell started without packet flag");

  property p_hdr_sel;
    @(posedge clk) disable iff (!rst_n)
    s_cell_start |=> use_ctrl == $past(f_data[isc_pkg::CTRL_BIT]);
  endproperty
  a_hdr_sel: assert property (p_hdr_sel)
    else $error("header type does not follow marker bit");

  property p_hdr_byte;
    @(posedge clk) disable iff (!rst_n)
    (state == isc_pkg::ISC_HDR && free) |=> byte_q == isc_pkg::hdr_byte(
      $past(use_ctrl) ? ~$past(sw_s2[2*HW-1:HW]) : ~$past(sw_s2[HW-1:0]),
      $past(cnt));
  endproperty
  a_hdr_byte: assert property (p_hdr_byte)
    else $error("header byte differs from switch setting");

  // Control bank alone, so a swapped mux leg shows up here
  property p_ctrl_cell;
    @(posedge clk) disable iff (!rst_n)
    (state == isc_pkg::ISC_HDR && free && use_ctrl) |=> byte_q == isc_pkg::hdr_byte(
      ~$past(sw_s2[2*HW-1:HW]), $past(cnt));
  endproperty
  a_ctrl_cell: assert property (p_ctrl_cell)
    else $error("control cell lacks control header");

  property p_pay_byte;
    @(posedge clk) disable iff (!rst_n)
    pop |=> byte_q == $past(f_data[isc_pkg::DATA_W-1:0]) && req != $past(req);
  endproperty
  a_pay_byte: assert property (p_pay_byte)
    else $error("payload byte altered");

  property p_cell_len;
    @(posedge clk) disable iff (!rst_n)
    (pop && cnt == 6'(isc_pkg::PAYLOAD_LEN - 1))
      |-> sent_cnt == 6'(isc_pkg::CELL_LEN - 1) ##1 state == isc_pkg::ISC_IDLE;
  endproperty
  a_cell_len: assert property (p_cell_len)
    else $error("cell length is not 53 bytes");

  property p_ctrl_bit;
    @(posedge clk) disable iff (!rst_n)
    wr_evt |-> wr_word[isc_pkg::CTRL_BIT] == in_s2[isc_pkg::IN_W];
  endproperty
  a_ctrl_bit: assert property (p_ctrl_bit)
    else $error("marker bit lost on write");

  property p_tx_pulse;
    @(posedge tx_clk) disable iff (!trst_n)
    tx_strobe |=> !tx_strobe;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse)
    else $error("output strobe longer than one cycle");

endmodule

/* File: tb/isc_net_sink.sv */
module isc_net_sink (
  // Output link
  input  wire logic                         tx_clk,
  input  wire logic [isc_pkg::DATA_W-1:0]   tx_data,
  input  wire logic                         tx_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [isc_pkg::DATA_W-1:0] got [$];

  // Network side never stalls, so every strobe is one byte taken
  always @(posedge tx_clk)
  begin
    if (tx_strobe === 1'b1)
    begin
      got.push_back(tx_data);
    end
  end
endmodule

/* File: tb/image_stream_cell_packetizer_bench.sv */
module image_stream_cell_packetizer_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic                        clk;
  logic                        rst_n;
  logic                        tx_clk;
  logic                        in_toggle;
  logic                        in_ctrl;
  logic                        in_full;
  logic                        tx_strobe;
  logic [isc_pkg::IN_W-1:0]    in_word;
  logic [isc_pkg::HDR_W-1:0]   sw_ctrl_n;
  logic [isc_pkg::HDR_W-1:0]   sw_data_n;
  logic [isc_pkg::DATA_W-1:0]  tx_data;
  logic [7:0]                  want [$];
  int                          bad_count;
  int                          checks_done;

  initial clk = 1'b0;
  always #50 clk = ~clk;
  initial tx_clk = 1'b0;
  always #7.5 tx_clk = ~tx_clk;

  isc_packetizer u_dut (
    .clk           (clk),
    .rst_n         (rst_n),
    .in_word       (in_word),
    .in_ctrl       (in_ctrl),
    .in_toggle     (in_toggle),
    .in_full       (in_full),
    .hdr_ctrl_sw_n (sw_ctrl_n),
    .hdr_data_sw_n (sw_data_n),
    .tx_clk        (tx_clk),
    .tx_data       (tx_data),
    .tx_strobe     (tx_strobe)
  );

  isc_net_sink u_sink (
    .tx_clk    (tx_clk),
    .tx_data   (tx_data),
    .tx_strobe (tx_strobe)
  );

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Switch pins read low when on, first header byte is the top one
  function automatic logic [7:0] hdr_b(input logic [39:0] pins, input int i);
    return 8'((~pins) >> (8 * (4 - i)));
  endfunction

  task automatic push_hdr(input logic ctrl);
    for (int i = 0; i < 5; i++)
      want.push_back(hdr_b(ctrl ? sw_ctrl_n : sw_data_n, i));
  endtask

  // Later markers are random: only the head marker may pick the header
  task automatic send_words(input logic first_ctrl, input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      @(posedge clk);
      #1;
      in_word = {2'($urandom), d};
      in_ctrl = (i == 0) ? first_ctrl : 1'($urandom);
      in_toggle = ~in_toggle;
      want.push_back(d);
      repeat (isc_pkg::IN_WORD_CYC - 1) @(posedge clk);
    end
  endtask

  task automatic expect_cell(input string name);
    int n;
    n = 0;
    while (u_sink.got.size() < 53 && n < 800)
    begin
      @(posedge clk);
      n++;
    end
    check("cell length", 16'(u_sink.got.size() >= 53), 16'h0001);
    for (int i = 0; i < 53 && u_sink.got.size() > 0; i++)
      check("cell byte", 16'(u_sink.got.pop_front()), 16'(want.pop_front()));
    $display("Test %s done", name);
  endtask

  initial
  begin
    #1_000_000;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    rst_n = 1'b0;
    in_toggle = 1'b0;
    in_ctrl = 1'b0;
    in_word = 10'h000;
    sw_ctrl_n = ~isc_pkg::CTRL_HDR_DEF;
    sw_data_n = ~isc_pkg::DATA_HDR_DEF;
    void'($urandom(4693));
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // One short of a payload must not start a cell
    push_hdr(1'b0);
    send_words(1'b0, 47);
    repeat (300) @(posedge clk);
    check("early bytes", 16'(u_sink.got.size()), 16'h0000);
    check("full flag", 16'(in_full), 16'h0000);
    send_words(1'b0, 1);
    expect_cell("packet_flag");
    // Control then data back to back, factory headers
    push_hdr(1'b1);
    send_words(1'b1, 48);
    push_hdr(1'b0);
    send_words(1'b0, 48);
    expect_cell("control_cell");
    expect_cell("data_cell");
    // Random distinct headers, both cell types
    for (int k = 0; k < 4; k++)
    begin
      sw_ctrl_n = {8'($urandom), 32'($urandom)};
      sw_data_n = ~sw_ctrl_n;
      push_hdr(1'(k));
      send_words(1'(k), 48);
      expect_cell("random_header");
    end
    // Reset in mid-stream drops a partial payload
    send_words(1'b0, 20);
    #1;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    check("reset strobe", 16'(tx_strobe), 16'h0000);
    check("reset data", 16'(tx_data), 16'h0000);
    #1;
    rst_n = 1'b1;
    want.delete();
    push_hdr(1'b1);
    send_words(1'b1, 48);
    expect_cell("mid_reset");
    check("leftover", 16'(u_sink.got.size()), 16'h0000);
    report_and_stop();
  end
endmodule
